// ---- dv/tps_central.sv ----
// Behavioural central unit: track control level and accessory commands.
`default_nettype none
module tps_central #(parameter HALF = 5) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        run,
    input  wire logic        send,
    input  wire logic [10:0] req_addr,
    output logic             track_lvl,
    output logic             acc_valid,
    output logic [10:0]      acc_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // The level stands still outside frames; address lines churn between commands.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            track_lvl <= 1'b0;
            acc_valid <= 1'b0;
            acc_addr <= 11'h000;
        end else begin
            cnt <= (run && cnt < HALF - 1) ? cnt + 1 : 0;
            if (run && cnt == HALF - 1) begin
                track_lvl <= ~track_lvl;
            end
            acc_valid <= send;
            acc_addr <= send ? req_addr : ~acc_addr;
        end
    end
endmodule
`default_nettype wire

// ---- dv/tps_sup_asserts.sv ----
// Port checker of the track power supervisor.
`default_nettype none
module tps_sup_asserts #(parameter MS_CYCLES = 10) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       wired_booster_input_port,
    input wire logic       node_track_in,
    input wire logic       cutout_win,
    input wire logic       overtemp,
    input wire logic       stop_go_button,
    input wire logic       fb_valid,
    input wire logic       fb_chan2,
    input wire logic       fb_dcc,
    input wire logic       fb_autoreg,
    input wire logic [7:0] fb_data,
    input wire logic       track_pos,
    input wire logic       track_neg,
    input wire logic       sc_msg,
    input wire logic       fb_out_valid,
    input wire logic [7:0] fb_out_data,
    input wire logic       go
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Only a DCC channel-2 reply that is no registration reply may pass.
    sequence s_fb_ok;
        fb_valid && fb_chan2 && fb_dcc && !fb_autoreg;
    endsequence
    sequence s_fb_out;
        fb_out_valid && fb_out_data == $past(fb_data);
    endsequence
    property p_fb_fwd;
        s_fb_ok |=> s_fb_out;
    endproperty
    property p_fb_block;
        fb_out_valid |-> $past(fb_valid && fb_chan2 && fb_dcc && !fb_autoreg);
    endproperty
    property p_leg_excl;
        !(track_pos && track_neg);
    endproperty
    // A leg moves in steady GO only two cycles after the control level moved.
    property p_leg_cause;
        $changed(track_pos) && go && $past(go, 3) && !cutout_win && !$past(cutout_win) && !$past(cutout_win, 2)
            |-> $past(wired_booster_input_port, 2) != $past(wired_booster_input_port, 3)
             || $past(node_track_in, 2) != $past(node_track_in, 3);
    endproperty
    property p_stop_legs;
        !go && !$past(go) |-> !track_pos && !track_neg;
    endproperty
    property p_sc;
        sc_msg |=> !sc_msg ##[0:1] !go;
    endproperty
    property p_heat_off;
        overtemp |-> ##[1:3] !go;
    endproperty
    property p_heat_lock;
        $rose(go) |-> !$past(overtemp, 2);
    endproperty
    property p_btn_stop;
        stop_go_button && go |-> ##2 !go;
    endproperty
    a_fb_fwd: assert property (p_fb_fwd) else $error("reply not forwarded");
    a_fb_block: assert property (p_fb_block) else $error("reply wrongly forwarded");
    a_leg_excl: assert property (p_leg_excl) else $error("both legs high");
    a_leg_cause: assert property (p_leg_cause) else $error("leg moved without cause");
    a_stop_legs: assert property (p_stop_legs) else $error("legs live in STOP");
    a_sc: assert property (p_sc) else $error("trip message wrong");
    a_heat_off: assert property (p_heat_off) else $error("no heat stop");
    a_heat_lock: assert property (p_heat_lock) else $error("GO while hot");
    a_btn_stop: assert property (p_btn_stop) else $error("button did not stop");
endmodule
bind tps_supervisor tps_sup_asserts #(.MS_CYCLES(MS_CYCLES)) u_tps_sup_asserts (
    .pclk(pclk), .presetn(presetn), .wired_booster_input_port(wired_booster_input_port),
    .node_track_in(node_track_in), .cutout_win(cutout_win), .overtemp(overtemp), .stop_go_button(stop_go_button),
    .fb_valid(fb_valid), .fb_chan2(fb_chan2), .fb_dcc(fb_dcc), .fb_autoreg(fb_autoreg), .fb_data(fb_data),
    .track_pos(track_pos), .track_neg(track_neg), .sc_msg(sc_msg), .fb_out_valid(fb_out_valid),
    .fb_out_data(fb_out_data), .go(go)
);
`default_nettype wire

// ---- dv/tps_supervisor_tb.sv ----
// Self-checking bench of the track power supervisor.
`include "tps_defs.vh"
`default_nettype none
module tps_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 2;
    logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, run = '0, send = '0, e;
    logic        cutout_win = '0, overtemp = '0, stop_go_button = '0, fb_valid = '0, fb_chan2 = '0;
    logic        fb_dcc = '0, fb_autoreg = '0, pready, pslverr, lvl, acc_valid, track_pos, track_neg;
    logic        track_drive, sc_line, sc_msg, fb_out_valid, go, nti = '0;
    logic [7:0]  paddr = '0, fb_data = '0, fb_out_data;
    logic [31:0] pwdata = '0, prdata, r;
    logic [2:0]  amps = '0;
    logic [10:0] acc_addr, req_addr = '0;
    int          failures = 0, check_count = 0, n, trips = 0;
    always #4 pclk = ~pclk;
    tps_supervisor #(.MS_CYCLES(MS)) u_tps_supervisor (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wired_booster_input_port(lvl),
        .node_track_in(nti), .cutout_win(cutout_win), .amps(amps), .overtemp(overtemp),
        .stop_go_button(stop_go_button), .acc_valid(acc_valid), .acc_addr(acc_addr), .fb_valid(fb_valid),
        .fb_chan2(fb_chan2), .fb_dcc(fb_dcc), .fb_autoreg(fb_autoreg), .fb_data(fb_data), .track_pos(track_pos),
        .track_neg(track_neg), .track_drive(track_drive), .sc_line(sc_line), .sc_msg(sc_msg),
        .fb_out_valid(fb_out_valid), .fb_out_data(fb_out_data), .go(go)
    );
    tps_central u_tps_central (
        .pclk(pclk), .presetn(presetn), .run(run), .send(send), .req_addr(req_addr),
        .track_lvl(lvl), .acc_valid(acc_valid), .acc_addr(acc_addr)
    );
    // Trip messages are one-cycle pulses, so a plain count per edge works.
    always @(posedge pclk) begin
        if (sc_msg === 1'b1) trips++;
    end
    task automatic chk(input logic [31:0] g, x);
        check_count++;
        if (g !== x) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic clk(input int c);
        repeat (c) @(posedge pclk);
    endtask
    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata;
        e = pslverr;
        if (k >= 50) chk(0, 1);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(a, 0, 0);
        chk(r, x);
    endtask
    task automatic wgo(input logic v, input int lim);
        n = 0;
        while (go !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic btn;
        stop_go_button <= 1;
        clk(1);
        stop_go_button <= 0;
        clk(3);
    endtask
    task automatic acc(input logic [10:0] a);
        req_addr <= a;
        send <= 1;
        clk(1);
        send <= 0;
        clk(5);
    endtask
    task automatic fb(input logic c2, dc, ar);
        fb_valid <= 1;
        fb_chan2 <= c2;
        fb_dcc <= dc;
        fb_autoreg <= ar;
        fb_data <= fb_data + 8'h3B;
        clk(1);
        fb_valid <= 0;
        clk(1);
        chk(fb_out_valid, c2 && dc && !ar);
        if (c2 && dc && !ar) chk(fb_out_data, fb_data);
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence: registers, track path, feedback, protection, watchdog.
    initial begin
        clk(4);
        presetn <= 1;
        clk(2);
        rd(`TPS_A_CTRL, 32'h00000001);
        rd(`TPS_A_OCP, 32'h00640664);
        rd(`TPS_A_RESTART, 32'h00003C04);
        rd(`TPS_A_STATUS, 32'h00000000);
        rd(8'h14, 32'h00000000);
        chk(e, 1);
        apb(`TPS_A_OCP, 1, 32'h07FF0705);
        rd(`TPS_A_OCP, 32'h01F40614);
        apb(`TPS_A_OCP, 1, 32'h00000214);
        apb(`TPS_A_RESTART, 1, 32'h00000204);
        apb(`TPS_A_CTRL, 1, 32'h00000009);
        apb(`TPS_A_ACCADDR, 1, 32'h00000123);
        btn;
        chk(go, 1);
        run <= 1;
        clk(20);
        r[0] = track_pos;
        n = 0;
        repeat (50) begin
            clk(1);
            if (track_pos !== r[0]) n++;
            if (track_pos === track_neg) n = 99;
            r[0] = track_pos;
        end
        chk(n, 10);
        cutout_win <= 1;
        clk(3);
        chk({track_pos, track_neg, track_drive}, 0);
        cutout_win <= 0;
        apb(`TPS_A_CTRL, 1, 32'h00000008);
        cutout_win <= 1;
        clk(3);
        chk(track_drive, 1);
        cutout_win <= 0;
        // Node-bus input: freeze the wired level and match it first, so the source swap makes no edge.
        run <= 0;
        clk(2);
        nti <= lvl;
        apb(`TPS_A_CTRL, 1, 32'h0000000C);
        r[0] = track_pos;
        n = 0;
        for (int i = 0; i < 48; i++) begin
            if (i % 8 == 0) nti <= ~nti;
            clk(1);
            if (track_pos !== r[0]) n++;
            r[0] = track_pos;
        end
        chk(n, 6);
        apb(`TPS_A_CTRL, 1, 32'h00000008);
        run <= 1;
        for (int i = 0; i < 8; i++) fb(i[0], i[1], i[2]);
        btn;
        chk(go, 0);
        btn;
        amps <= 3'h1;
        clk(60);
        chk(go, 1);
        amps <= 3'h2;
        clk(35);
        chk(go, 1);
        wgo(0, 20);
        chk(n < 20, 1);
        chk(sc_line, 1);
        for (int i = 0; i < 5; i++) begin
            wgo(1, 9000);
            chk((n + 5) / 10, i < 4 ? 800 : 400);
            if (i < 4) begin
                wgo(0, 4);
                chk(n < 4, 1);
            end
            if (i == 3) amps <= 3'h0;
            if (i == 3) apb(`TPS_A_OCP, 1, 32'h00320214);
        end
        chk(trips, 5);
        apb(`TPS_A_STATUS, 0, 0);
        chk(r[7:0], 8'h21);
        amps <= 3'h5;
        clk(120);
        chk(go, 1);
        wgo(0, 40);
        chk(n < 40, 1);
        amps <= 3'h0;
        wgo(1, 9000);
        apb(`TPS_A_CTRL, 1, 32'h0000000A);
        overtemp <= 1;
        clk(1);
        overtemp <= 0;
        clk(3);
        chk(go, 0);
        clk(200);
        chk(go, 0);
        apb(`TPS_A_STATUS, 0, 0);
        chk({r[9:5]}, 5'h0C);
        acc(11'h124);
        chk(go, 0);
        acc(11'h123);
        chk(go, 1);
        apb(`TPS_A_STATUS, 0, 0);
        chk(r[9], 1);
        wgo(0, 11000);
        chk((n + 50) / 100, 100);
        complete_run;
    end
    // Hang guard, sized well above the longest expected run.
    initial begin
        clk(70000);
        failures++;
        complete_run;
    end
endmodule
`default_nettype wire

// ---- shared/tps_defs.vh ----
// Constants, register map and timing figures of the track power supervisor.
// Summary of operation
// - Reverse output polarity on every input level change.
// - Forward all formats; no proprietary-format decoder feedback.
// - Feedback cutout switchable, enabled after reset.
// - Pass channel-2 decoder replies onward to node bus.
// - Overcurrent for sensitivity time forces STOP.
// - Trip threshold 2 to 6 A, 1 A steps.
// - Drive short-circuit feedback line on overcurrent.
// - Own output switches off without feedback line.
// - Emit short-circuit status message on node bus.
// - Restart after 4-10 s; retrip at once.
// - Five retrips pause restart 0-90 s, default 60.
// - Inrush window tolerates up to 6 A.
// - Overtemperature switches the track output off.
// - Missing watchdog commands switch the output off.
// - Watchdog armed only by first matching command.
// - Never forward auto-registration extension replies.
// - Autostart never undoes button, heat or watchdog stop.
// - Matching accessory command toggles STOP and GO.
`ifndef TPS_DEFS_VH
`define TPS_DEFS_VH

// Register byte offsets.
`define TPS_A_CTRL     8'h00
`define TPS_A_OCP      8'h04
`define TPS_A_RESTART  8'h08
`define TPS_A_ACCADDR  8'h0C
`define TPS_A_STATUS   8'h10

// Control bits.
`define TPS_C_CUTOUT   0
`define TPS_C_AUTO     1
`define TPS_C_SRC      2
`define TPS_C_FBLINE   3
`define TPS_CTRL_RST   4'h1

// Overcurrent register fields and limits.
`define TPS_SENS_MIN   8'h14
`define TPS_SENS_MAX   8'hC8
`define TPS_SENS_RST   8'h64
`define TPS_THR_MIN    3'h2
`define TPS_THR_MAX    3'h6
`define TPS_THR_RST    3'h6
`define TPS_INRUSH_AMP 3'h6
`define TPS_INR_MAX    9'h1F4
`define TPS_INR_RST    9'h064

// Restart register fields and limits, seconds.
`define TPS_RS_MIN     4'h4
`define TPS_RS_MAX     4'hA
`define TPS_RS_RST     4'h4
`define TPS_PS_MAX     7'h5A
`define TPS_PS_RST     7'h3C
`define TPS_RETRIES    3'h5

// Timing: milliseconds per second, watchdog span, clock period.
`define TPS_MS_PER_S   17'h003E8
`define TPS_WD_MS      17'h01388
`define TPS_MS_NS      1000000
`define TPS_CLK_NS     8

`endif

// ---- verilog/tps_ms_timer.v ----
// Millisecond down-counter with a sticky expired level.
`default_nettype none

module tps_ms_timer (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        tick,
    input  wire        load,
    input  wire [16:0] value,
    output reg         expired
);

    reg [16:0] count;

    // Load restarts the span; a zero span expires at once so a zero pause works.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count   <= 17'h00000;
            expired <= 1'b0;
        end else if (load) begin
            count   <= value;
            expired <= (value == 17'h00000);
        end else if (tick && !expired) begin
            count   <= count - 17'h00001;
            expired <= (count == 17'h00001);
        end
    end

endmodule

`default_nettype wire

// ---- verilog/tps_supervisor.v ----
// Track power supervisor: polarity stage, protection, watchdog and APB registers.
`include "tps_defs.vh"
`default_nettype none

module tps_supervisor #(
    parameter MS_CYCLES = `TPS_MS_NS / `TPS_CLK_NS
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        wired_booster_input_port,
    input  wire        node_track_in,
    input  wire        cutout_win,
    input  wire [2:0]  amps,
    input  wire        overtemp,
    input  wire        stop_go_button,
    input  wire        acc_valid,
    input  wire [10:0] acc_addr,
    input  wire        fb_valid,
    input  wire        fb_chan2,
    input  wire        fb_dcc,
    input  wire        fb_autoreg,
    input  wire [7:0]  fb_data,
    output reg         track_pos,
    output reg         track_neg,
    output reg         track_drive,
    output reg         sc_line,
    output reg         sc_msg,
    output reg         fb_out_valid,
    output reg  [7:0]  fb_out_data,
    output reg         go
);

    localparam ST_STOP  = 2'b00;
    localparam ST_GO    = 2'b01;
    localparam ST_WAIT  = 2'b10;
    localparam ST_PAUSE = 2'b11;

    reg  [1:0]  state;
    reg  [3:0]  ctrl;
    reg  [7:0]  sens_ms;
    reg  [2:0]  thresh;
    reg  [8:0]  inrush_ms;
    reg  [3:0]  restart_s;
    reg  [6:0]  pause_s;
    reg  [10:0] acc_own;
    reg  [16:0] prescale;
    reg         ms_tick;
    reg         sig_prev;
    reg         polarity;
    reg         sig_seen;
    reg         stop_lock;
    reg         restarted;
    reg         wd_active;
    reg  [2:0]  retrips;
    reg  [2:0]  cause;
    reg         ld_rst;
    reg  [16:0] rst_val;
    wire        sens_done;
    wire        inr_done;
    wire        rst_done;
    wire        wd_done;

    ////////////////////////////////////////////////////////////////////////////
    // Combinational helpers.

    wire        sig_in  = ctrl[`TPS_C_SRC] ? node_track_in : wired_booster_input_port;
    wire        acc_hit = acc_valid && (acc_addr == acc_own);
    wire        toggle  = acc_hit || stop_go_button;
    // Inside the inrush window the fixed 6 A ceiling replaces the threshold.
    wire        oc      = !inr_done ? (amps > `TPS_INRUSH_AMP)
                                    : (amps >= thresh);
    wire        trip    = (state == ST_GO) && oc &&
                          (sens_done || restarted);
    wire        wd_trip = wd_active && wd_done && (state == ST_GO);
    wire        enter_go;
    wire        apb_wr  = psel && penable && pwrite;
    wire        apb_set = psel && !penable;

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond prescaler shared by every timer.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= 17'h00000;
            ms_tick  <= 1'b0;
        end else if (prescale == MS_CYCLES[16:0] - 17'h00001) begin
            prescale <= 17'h00000;
            ms_tick  <= 1'b1;
        end else begin
            prescale <= prescale + 17'h00001;
            ms_tick  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timers. Sensitivity reloads while current is fine, so only a continuous
    // overcurrent lets it run out.

    tps_ms_timer u_sens (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (ms_tick),
        .load    (!oc || state != ST_GO),
        .value   ({9'h000, sens_ms}),
        .expired (sens_done)
    );

    tps_ms_timer u_inrush (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (ms_tick),
        .load    (enter_go),
        .value   ({8'h00, inrush_ms}),
        .expired (inr_done)
    );

    tps_ms_timer u_restart (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (ms_tick),
        .load    (ld_rst),
        .value   (rst_val),
        .expired (rst_done)
    );

    tps_ms_timer u_wd (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (ms_tick),
        .load    (acc_hit),
        .value   (`TPS_WD_MS),
        .expired (wd_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Protection state machine.

    assign enter_go = (state != ST_GO) && !overtemp && (
                      (state == ST_STOP && toggle) ||
                      (state == ST_STOP && !stop_lock && ctrl[`TPS_C_AUTO] && sig_seen) ||
                      (state == ST_WAIT && rst_done) ||
                      (state == ST_PAUSE && rst_done));

    // Restart timer load value: delay after a trip, pause after the last retry,
    // clean-running interval while in GO.
    always @* begin
        ld_rst  = 1'b0;
        rst_val = {13'h0000, restart_s} * `TPS_MS_PER_S;
        if (trip && retrips == `TPS_RETRIES - 3'h1) begin
            ld_rst  = 1'b1;
            rst_val = {10'h000, pause_s} * `TPS_MS_PER_S;
        end else if (trip || enter_go || (state == ST_GO && oc)) begin
            ld_rst  = 1'b1;
        end
    end

    // Button, heat and watchdog stops lock out autostart; a trip does not.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ST_STOP;
            stop_lock <= 1'b0;
            restarted <= 1'b0;
            retrips   <= 3'h0;
            cause     <= 3'h0;
            sig_seen  <= 1'b0;
            wd_active <= 1'b0;
        end else begin
            if (sig_in != sig_prev)
                sig_seen <= 1'b1;
            if (acc_hit)
                wd_active <= 1'b1;
            if (overtemp) begin
                state     <= ST_STOP;
                stop_lock <= 1'b1;
                cause     <= 3'h4;
            end else if (wd_trip) begin
                state     <= ST_STOP;
                stop_lock <= 1'b1;
                cause     <= 3'h2;
            end else if (trip) begin
                cause     <= 3'h1;
                restarted <= 1'b0;
                if (retrips == `TPS_RETRIES - 3'h1)
                    state <= ST_PAUSE;
                else
                    state <= ST_WAIT;
                retrips   <= retrips + 3'h1;
            end else if (state == ST_GO && toggle) begin
                state     <= ST_STOP;
                stop_lock <= 1'b1;
                cause     <= 3'h0;
            end else if (enter_go) begin
                state     <= ST_GO;
                stop_lock <= 1'b0;
                restarted <= (state == ST_WAIT);
                if (state == ST_PAUSE || state == ST_STOP)
                    retrips <= 3'h0;
            end else if (state == ST_GO && rst_done) begin
                retrips   <= 3'h0;
                restarted <= 1'b0;
            end else if (state != ST_GO && toggle) begin
                state     <= ST_STOP;
                stop_lock <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output stage. Both legs fall together during an enabled cutout gap.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sig_prev    <= 1'b0;
            polarity    <= 1'b0;
            track_pos   <= 1'b0;
            track_neg   <= 1'b0;
            track_drive <= 1'b0;
            go          <= 1'b0;
            sc_line     <= 1'b0;
            sc_msg      <= 1'b0;
        end else begin
            sig_prev    <= sig_in;
            if (sig_in != sig_prev)
                polarity <= !polarity;
            go          <= (state == ST_GO);
            track_drive <= (state == ST_GO) && !(cutout_win && ctrl[`TPS_C_CUTOUT]);
            track_pos   <= (state == ST_GO) && polarity && !(cutout_win && ctrl[`TPS_C_CUTOUT]);
            track_neg   <= (state == ST_GO) && !polarity && !(cutout_win && ctrl[`TPS_C_CUTOUT]);
            sc_line     <= ctrl[`TPS_C_FBLINE] && (trip ||
                           ((state == ST_WAIT || state == ST_PAUSE) && !enter_go));
            sc_msg      <= trip;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoder feedback forwarding.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_out_valid <= 1'b0;
            fb_out_data  <= 8'h00;
        end else begin
            fb_out_valid <= fb_valid && fb_chan2 && fb_dcc && !fb_autoreg;
            if (fb_valid)
                fb_out_data <= fb_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states; read data and error are prepared in the
    // setup cycle so they leave flip-flops during the access cycle.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl      <= `TPS_CTRL_RST;
            sens_ms   <= `TPS_SENS_RST;
            thresh    <= `TPS_THR_RST;
            inrush_ms <= `TPS_INR_RST;
            restart_s <= `TPS_RS_RST;
            pause_s   <= `TPS_PS_RST;
            acc_own   <= 11'h000;
            prdata    <= 32'h00000000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (apb_set) begin
                pslverr <= 1'b0;
                if (paddr == `TPS_A_CTRL)
                    prdata <= {28'h0000000, ctrl};
                else if (paddr == `TPS_A_OCP)
                    prdata <= {7'h00, inrush_ms, 5'h00, thresh, sens_ms};
                else if (paddr == `TPS_A_RESTART)
                    prdata <= {17'h00000, pause_s, 4'h0, restart_s};
                else if (paddr == `TPS_A_ACCADDR)
                    prdata <= {21'h000000, acc_own};
                else if (paddr == `TPS_A_STATUS)
                    prdata <= {22'h000000, wd_active, stop_lock, cause, retrips, state};
                else begin
                    prdata  <= 32'h00000000;
                    pslverr <= 1'b1;
                end
            end
            if (apb_wr) begin
                if (paddr == `TPS_A_CTRL)
                    ctrl <= pwdata[3:0];
                else if (paddr == `TPS_A_OCP) begin
                    // Out-of-range settings are clamped to the nearest legal value.
                    sens_ms <= (pwdata[7:0] < `TPS_SENS_MIN) ? `TPS_SENS_MIN :
                               (pwdata[7:0] > `TPS_SENS_MAX) ? `TPS_SENS_MAX : pwdata[7:0];
                    thresh  <= (pwdata[10:8] < `TPS_THR_MIN) ? `TPS_THR_MIN :
                               (pwdata[10:8] > `TPS_THR_MAX) ? `TPS_THR_MAX : pwdata[10:8];
                    inrush_ms <= (pwdata[24:16] > `TPS_INR_MAX) ? `TPS_INR_MAX : pwdata[24:16];
                end else if (paddr == `TPS_A_RESTART) begin
                    restart_s <= (pwdata[3:0] < `TPS_RS_MIN) ? `TPS_RS_MIN :
                                 (pwdata[3:0] > `TPS_RS_MAX) ? `TPS_RS_MAX : pwdata[3:0];
                    pause_s   <= (pwdata[14:8] > `TPS_PS_MAX) ? `TPS_PS_MAX : pwdata[14:8];
                end else if (paddr == `TPS_A_ACCADDR)
                    acc_own <= pwdata[10:0];
            end
        end
    end

endmodule

`default_nettype wire
